// [design/srsbp_pkg.sv]
// constants and types shared by the serial clock/calendar sram bus port
package srsbp_pkg;

  // bus addressing
  localparam logic [7:0]  SLAVE_ADDR_BYTE = 8'hD0;
  localparam int          ADDR_W          = 15;
  localparam int          RAM_BYTES_DEF   = 32752;
  localparam logic [14:0] RSVD_FIRST      = 15'h7FF0;
  localparam logic [14:0] RSVD_LAST       = 15'h7FF6;
  localparam logic [14:0] A_SUBSEC        = 15'h7FF7;
  localparam logic [14:0] A_CAL           = 15'h7FF8;
  localparam logic [14:0] A_SEC           = 15'h7FF9;
  localparam logic [14:0] A_MIN           = 15'h7FFA;
  localparam logic [14:0] A_HOUR          = 15'h7FFB;
  localparam logic [14:0] A_DAY           = 15'h7FFC;
  localparam logic [14:0] A_DATE          = 15'h7FFD;
  localparam logic [14:0] A_MONTH         = 15'h7FFE;
  localparam logic [14:0] A_YEAR          = 15'h7FFF;

  // control register field
  localparam int          CAL_WRITE_BIT   = 7;

  // bcd limits and reset values
  localparam logic [7:0]  SUBSEC_MAX      = 8'h99;
  localparam logic [7:0]  MINSEC_MAX      = 8'h59;
  localparam logic [7:0]  HOUR_MAX        = 8'h23;
  localparam logic [7:0]  DAY_MAX         = 8'h07;
  localparam logic [7:0]  MONTH_MAX       = 8'h12;
  localparam logic [7:0]  YEAR_MAX        = 8'h99;
  localparam logic [7:0]  BCD_ZERO        = 8'h00;
  localparam logic [7:0]  BCD_ONE         = 8'h01;

  // timing
  localparam int          CLK_FREQ_HZ     = 250000000;
  localparam int          RECOVERY_DELAY_US = 1000;
  localparam int          RECOVERY_CYCLES_DEF =
    RECOVERY_DELAY_US * (CLK_FREQ_HZ / 1000000);
  localparam logic [16:0] OSC_WRAP        = 17'h08000;
  localparam logic [16:0] SUBSEC_STEP     = 17'h00064;

  // byte events from the link side
  typedef enum logic [1:0] {
    EV_ADDR     = 2'b00,
    EV_WRITE    = 2'b01,
    EV_READ_ACK = 2'b10
  } srsbp_ev_e;

  // what the next written byte means
  typedef enum logic [1:0] {
    ST_ADDR_HI = 2'b00,
    ST_ADDR_LO = 2'b01,
    ST_DATA    = 2'b10
  } srsbp_stage_e;

endpackage

// [design/srsbp_top.sv]
// two-wire slave port with byte pointer, ram and bcd clock/calendar
`timescale 1ns/1ps
module srsbp_top
#(
  parameter int RAM_BYTES       = srsbp_pkg::RAM_BYTES_DEF,
  parameter int RECOVERY_CYCLES = srsbp_pkg::RECOVERY_CYCLES_DEF
)
(
  // system
  input  wire logic clock,
  input  wire logic arst_n,
  // serial bus
  input  wire logic scl,
  input  wire logic sda_in,
  output wire logic sda_out,
  output wire logic sda_oe_n,
  // time base
  input  wire logic osc_32k,
  // supply monitor
  input  wire logic power_fail_in,
  input  wire logic battery_switch_in,
  // open drain system reset
  output wire logic reset_out,
  output wire logic reset_oe_n
);
  import srsbp_pkg::*;

  typedef struct packed {
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic       first_done;
    logic       active;
    logic       rd;
    logic       nack;
  } srsbp_link_s;

  typedef struct packed {
    logic       tgl;
    srsbp_ev_e  kind;
    logic [7:0] data;
  } srsbp_lev_s;

  typedef struct packed {
    logic [7:0] tx_sh;
    logic       sda_low;
  } srsbp_neg_s;

  typedef struct packed {
    logic         pf_s1;
    logic         pf_s2;
    logic         bs_s1;
    logic         bs_s2;
    logic         osc_s1;
    logic         osc_s2;
    logic         osc_d;
    logic         scl_s1;
    logic         scl_s2;
    logic         scl_d;
    logic         sda_s1;
    logic         sda_s2;
    logic         sda_d;
    logic         ev_s1;
    logic         ev_s2;
    logic         ev_d;
    logic         link_clr;
    logic         prot;
    logic [31:0]  rec_cnt;
    srsbp_stage_e stage;
    logic [14:0]  ptr;
    logic [7:0]   tx_byte;
    logic [15:0]  acc;
    logic [7:0]   subsec;
    logic [7:0]   cal;
    logic [7:0]   sec;
    logic [7:0]   min;
    logic [7:0]   hour;
    logic [7:0]   day;
    logic [7:0]   date;
    logic [7:0]   month;
    logic [7:0]   year;
    logic         rst_drive;
  } srsbp_sys_s;

  localparam srsbp_sys_s SYS_RST = '{
    stage: ST_ADDR_HI, day: BCD_ONE, date: BCD_ONE, month: BCD_ONE,
    default: '0};

  // bcd step with wrap from hi back to lo
  function automatic logic [7:0] bcd_wrap(input logic [7:0] v,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi);
    if (v == hi)
      return lo;
    else if (v[3:0] == 4'h9)
      return {v[7:4] + 4'h1, 4'h0};
    else
      return v + 8'h01;
  endfunction

  // years 2000..2099, every fourth one leaps
  function automatic logic is_leap(input logic [7:0] y);
    if (y[4])
      return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    else
      return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction

  function automatic logic [7:0] month_len(input logic [7:0] m,
                                           input logic [7:0] y);
    case (m)
      8'h02:   return is_leap(y) ? 8'h29 : 8'h28;
      8'h04,
      8'h06,
      8'h09,
      8'h11:   return 8'h30;
      default: return 8'h31;
    endcase
  endfunction

  srsbp_link_s lk;
  srsbp_link_s next_lk;
  srsbp_lev_s  lev;
  srsbp_lev_s  next_lev;
  srsbp_neg_s  ng;
  srsbp_neg_s  next_ng;
  srsbp_sys_s  s;
  srsbp_sys_s  next_s;
  logic        link_rst_n;
  logic        ram_we;
  logic [7:0]  ram_rd;
  logic [7:0]  mem [RAM_BYTES];

  // link logic is cleared by every start, stop and protected interval
  assign link_rst_n = arst_n & ~s.link_clr;

  // link side, sampled on the rising serial clock
  always_comb
  begin
    next_lk  = lk;
    next_lev = lev;
    if (lk.bit_cnt == 4'd8)
    begin
      next_lk.bit_cnt    = 4'd0;
      next_lk.first_done = 1'b1;
      if (lk.active && lk.rd && lk.first_done)
      begin
        next_lk.nack  = sda_in;
        next_lev.kind = EV_READ_ACK;
        next_lev.tgl  = ~lev.tgl;
      end
    end
    else
    begin
      next_lk.shift   = {lk.shift[6:0], sda_in};
      next_lk.bit_cnt = lk.bit_cnt + 4'd1;
      if (lk.bit_cnt == 4'd7)
      begin
        if (!lk.first_done)
        begin
          next_lk.active = lk.shift[6:0] == SLAVE_ADDR_BYTE[7:1];
          next_lk.rd     = sda_in;
          if (next_lk.active)
          begin
            next_lev.kind = EV_ADDR;
            next_lev.data = {lk.shift[6:0], sda_in};
            next_lev.tgl  = ~lev.tgl;
          end
        end
        else if (lk.active && !lk.rd)
        begin
          next_lev.kind = EV_WRITE;
          next_lev.data = {lk.shift[6:0], sda_in};
          next_lev.tgl  = ~lev.tgl;
        end
      end
    end
  end

  always_ff @(posedge scl or negedge link_rst_n)
  begin
    if (!link_rst_n)
      lk <= '0;
    else
      lk <= next_lk;
  end

  // event toggle survives frame clears so no false event is seen
  always_ff @(posedge scl or negedge arst_n)
  begin
    if (!arst_n)
      lev <= '{tgl: 1'b0, kind: EV_ADDR, data: 8'h00};
    else
      lev <= next_lev;
  end

  // link side, driven on the falling serial clock
  always_comb
  begin
    logic       tx_en;
    logic [7:0] src;
    tx_en   = 1'b0;
    src     = 8'h00;
    next_ng = ng;
    tx_en   = lk.active && lk.rd && lk.first_done && !lk.nack
              && (lk.bit_cnt != 4'd8);
    // tx_byte settles well inside the clock high half, so no resync
    src           = (lk.bit_cnt == 4'd0) ? s.tx_byte : ng.tx_sh;
    next_ng.tx_sh = src;
    next_ng.sda_low = ((lk.bit_cnt == 4'd8) && lk.active
                       && (!lk.first_done || !lk.rd))
                      || (tx_en && !src[3'(4'd7 - lk.bit_cnt)]);
  end

  always_ff @(negedge scl or negedge link_rst_n)
  begin
    if (!link_rst_n)
      ng <= '0;
    else
      ng <= next_ng;
  end

  assign sda_out  = 1'b0;
  assign sda_oe_n = ~ng.sda_low;

  // system side
  always_comb
  begin
    logic        ev;
    logic        tick;
    logic [16:0] sum;
    logic [7:0]  dnext;
    ev     = 1'b0;
    tick   = 1'b0;
    sum    = 17'h00000;
    dnext  = 8'h00;
    ram_we = 1'b0;
    next_s = s;
    next_s.pf_s1  = power_fail_in;
    next_s.pf_s2  = s.pf_s1;
    next_s.bs_s1  = battery_switch_in;
    next_s.bs_s2  = s.bs_s1;
    next_s.osc_s1 = osc_32k;
    next_s.osc_s2 = s.osc_s1;
    next_s.osc_d  = s.osc_s2;
    next_s.scl_s1 = scl;
    next_s.scl_s2 = s.scl_s1;
    next_s.scl_d  = s.scl_s2;
    next_s.sda_s1 = sda_in;
    next_s.sda_s2 = s.sda_s1;
    next_s.sda_d  = s.sda_s2;
    next_s.ev_s1  = lev.tgl;
    next_s.ev_s2  = s.ev_s1;
    next_s.ev_d   = s.ev_s2;
    ev = s.ev_s2 ^ s.ev_d;

    if (s.pf_s2)
    begin
      next_s.prot    = 1'b1;
      next_s.rec_cnt = 32'(RECOVERY_CYCLES);
    end
    else if (s.rec_cnt != 32'h0)
      next_s.rec_cnt = s.rec_cnt - 32'h1;
    else
      next_s.prot = 1'b0;
    next_s.rst_drive = next_s.prot;

    // start, stop or protection resets the link side
    next_s.link_clr = (s.scl_s2 && s.scl_d && (s.sda_d != s.sda_s2))
                      || next_s.prot;

    // event kind and byte are stable for a byte time once toggled
    if (ev && !s.prot)
    begin
      case (lev.kind)
        EV_ADDR:
        begin
          if (!lev.data[0])
            next_s.stage = ST_ADDR_HI;
        end
        EV_WRITE:
        begin
          case (s.stage)
            ST_ADDR_HI:
            begin
              next_s.ptr[14:8] = lev.data[6:0];
              next_s.stage     = ST_ADDR_LO;
            end
            ST_ADDR_LO:
            begin
              next_s.ptr[7:0] = lev.data;
              next_s.stage    = ST_DATA;
            end
            ST_DATA:
            begin
              ram_we     = 32'(s.ptr) < RAM_BYTES;
              next_s.ptr = s.ptr + 15'h0001;
            end
            default:
              next_s.stage = ST_ADDR_HI;
          endcase
        end
        EV_READ_ACK:
          next_s.ptr = s.ptr + 15'h0001;
        default:
          next_s.stage = ST_ADDR_HI;
      endcase
    end
    if (s.pf_s2)
      next_s.ptr = 15'h0000;

    // hundredths from the 32768 Hz base by exact accumulation
    if (s.osc_s2 && !s.osc_d)
    begin
      sum = {1'b0, s.acc} + SUBSEC_STEP;
      if (sum >= OSC_WRAP)
      begin
        tick       = 1'b1;
        next_s.acc = 16'(sum - OSC_WRAP);
      end
      else
        next_s.acc = sum[15:0];
    end

    // write bit freezes the counters so a set is consistent
    if (tick && !s.cal[CAL_WRITE_BIT])
    begin
      next_s.subsec = bcd_wrap(s.subsec, BCD_ZERO, SUBSEC_MAX);
      if (s.subsec == SUBSEC_MAX)
      begin
        next_s.sec = bcd_wrap(s.sec, BCD_ZERO, MINSEC_MAX);
        if (s.sec == MINSEC_MAX)
        begin
          next_s.min = bcd_wrap(s.min, BCD_ZERO, MINSEC_MAX);
          if (s.min == MINSEC_MAX)
          begin
            next_s.hour = bcd_wrap(s.hour, BCD_ZERO, HOUR_MAX);
            if (s.hour == HOUR_MAX)
            begin
              dnext = bcd_wrap({5'h00, s.day[2:0]}, BCD_ONE, DAY_MAX);
              next_s.day  = {s.day[7:3], dnext[2:0]};
              next_s.date = bcd_wrap(s.date, BCD_ONE,
                                     month_len(s.month, s.year));
              if (s.date == month_len(s.month, s.year))
              begin
                next_s.month = bcd_wrap(s.month, BCD_ONE, MONTH_MAX);
                if (s.month == MONTH_MAX)
                  next_s.year = bcd_wrap(s.year, BCD_ZERO, YEAR_MAX);
              end
            end
          end
        end
      end
    end

    // a bus write wins over a same-cycle count
    if (ev && !s.prot && (lev.kind == EV_WRITE) && (s.stage == ST_DATA))
    begin
      case (s.ptr)
        A_SUBSEC: next_s.subsec = lev.data;
        A_CAL:    next_s.cal    = lev.data;
        A_SEC:    next_s.sec    = lev.data;
        A_MIN:    next_s.min    = lev.data;
        A_HOUR:   next_s.hour   = lev.data;
        A_DAY:    next_s.day    = lev.data;
        A_DATE:   next_s.date   = lev.data;
        A_MONTH:  next_s.month  = lev.data;
        A_YEAR:   next_s.year   = lev.data;
        default:  next_s.stage  = ST_DATA;
      endcase
    end

    // read byte follows the pointer every cycle
    case (next_s.ptr)
      A_SUBSEC: next_s.tx_byte = s.subsec;
      A_CAL:    next_s.tx_byte = s.cal;
      A_SEC:    next_s.tx_byte = s.sec;
      A_MIN:    next_s.tx_byte = s.min;
      A_HOUR:   next_s.tx_byte = s.hour;
      A_DAY:    next_s.tx_byte = s.day;
      A_DATE:   next_s.tx_byte = s.date;
      A_MONTH:  next_s.tx_byte = s.month;
      A_YEAR:   next_s.tx_byte = s.year;
      default:  next_s.tx_byte = (next_s.ptr >= RSVD_FIRST) ? 8'h00
                                 : ram_rd;
    endcase
  end

  assign ram_rd = (32'(next_s.ptr) < RAM_BYTES) ? mem[next_s.ptr] : 8'h00;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      s <= SYS_RST;
    else
      s <= next_s;
  end

  // ram contents are battery backed, so reset leaves them alone
  always_ff @(posedge clock)
  begin
    if (ram_we)
      mem[s.ptr] <= lev.data;
  end

  // on battery the reset output floats, the data pin is not gated
  assign reset_out  = 1'b0;
  assign reset_oe_n = ~(s.rst_drive && !s.bs_s2);

endmodule

// [tb/srsbp_properties.sv]
// pin-level assertions for the two-wire clock/calendar sram port
`timescale 1ns/1ps
module srsbp_properties
#(
  parameter int RAM_BYTES       = 32752,
  parameter int RECOVERY_CYCLES = 250000
)
(
  // system
  input wire logic clock,
  input wire logic arst_n,
  // serial bus
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // time base and supply monitor
  input wire logic osc_32k,
  input wire logic power_fail_in,
  input wire logic battery_switch_in,
  // system reset pin
  input wire logic reset_out,
  input wire logic reset_oe_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // cycles since the fail input dropped, saturating
  logic [15:0] pf_cnt;
  logic        pf_seen;
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
    begin
      pf_cnt  <= 16'h0000;
      pf_seen <= 1'b0;
    end
    else if (power_fail_in)
    begin
      pf_cnt  <= 16'h0000;
      pf_seen <= 1'b1;
    end
    else if (pf_cnt != 16'hFFFF)
      pf_cnt <= pf_cnt + 16'h0001;
  sequence pf_steady;
    (power_fail_in && !battery_switch_in) [*5];
  endsequence
  sequence recover_win;
    pf_seen && !power_fail_in && !battery_switch_in &&
      int'(pf_cnt) < RECOVERY_CYCLES;
  endsequence
  sequence drive_start;
    $fell(sda_oe_n);
  endsequence
  sda_open_a: assert property (sda_out == 1'b0)
    else $error("data pin drives high");
  rst_open_a: assert property (reset_out == 1'b0)
    else $error("reset pin drives high");
  fail_reset_a: assert property (pf_steady |-> !reset_oe_n)
    else $error("reset not held during power fail");
  battery_float_a: assert property (battery_switch_in [*4] |-> reset_oe_n)
    else $error("reset driven on battery");
  recover_hold_a: assert property (recover_win |-> !reset_oe_n)
    else $error("reset released before recovery delay");
  recover_end_a: assert property (pf_seen && !battery_switch_in &&
    int'(pf_cnt) == RECOVERY_CYCLES + 8 |-> reset_oe_n)
    else $error("reset still held after recovery delay");
  fail_quiet_a: assert property (power_fail_in [*6] |-> sda_oe_n)
    else $error("bus answered during power fail");
  drive_low_a: assert property (drive_start |-> !scl)
    else $error("data pulled low while clock high");
  ack_hold_a: assert property (drive_start |=> !sda_oe_n [*8])
    else $error("driven low bit not held");
endmodule
bind srsbp_top srsbp_properties #(
  .RAM_BYTES      (RAM_BYTES),
  .RECOVERY_CYCLES(RECOVERY_CYCLES)
) u_srsbp_properties (
  .clock(clock), .arst_n(arst_n), .scl(scl), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .osc_32k(osc_32k),
  .power_fail_in(power_fail_in), .battery_switch_in(battery_switch_in),
  .reset_out(reset_out), .reset_oe_n(reset_oe_n)
);

// [tb/srsbp_master.sv]
// bus master model driving the two-wire serial port
`timescale 1ns/1ps
module srsbp_master
(
  // bus lines, sda_m high means released
  output logic       scl,
  output logic       sda_m,
  input  wire logic  sda_wire,
  // one report per byte
  output logic       res_stb,
  output logic [8:0] res
);
  // quarter of the 48 ns link period
  localparam realtime Q = 12.0;
  initial
  begin
    scl     = 1'b1;
    sda_m   = 1'b1;
    res_stb = 1'b0;
    res     = 9'h000;
  end
  // odd offset keeps link edges unrelated to the system clock
  task automatic start(input logic rep);
    if (rep)
    begin
      scl = 1'b0;
      #(Q) sda_m = 1'b1;
      #(Q) scl = 1'b1;
      #(2*Q);
    end
    else
      #1.7;
    sda_m = 1'b0;
    #(2*Q);
  endtask
  task automatic stop();
    scl = 1'b0;
    #(Q) sda_m = 1'b0;
    #(Q) scl = 1'b1;
    #(2*Q) sda_m = 1'b1;
    #(4*Q);
  endtask
  // clock stays high after the ack slot until the next call
  task automatic xfer(input logic [7:0] d, input logic rd,
                      input logic ack);
    logic [7:0] b;
    logic       a;
    for (int i = 7; i >= 0; i--)
    begin
      scl = 1'b0;
      #(Q) sda_m = rd | d[i];
      #(Q) scl = 1'b1;
      b[i] = sda_wire;
      #(2*Q);
    end
    scl = 1'b0;
    #(Q) sda_m = !(rd && ack);
    #(Q) scl = 1'b1;
    a = sda_wire;
    res = rd ? {1'b1, b} : {8'h00, !a};
    res_stb = 1'b1;
    #1 res_stb = 1'b0;
    #(2*Q - 1);
  endtask
endmodule

// [tb/serial_rtc_sram_bus_port_test.sv]
// self-checking bench for the two-wire clock/calendar sram port
`timescale 1ns/1ps
module serial_rtc_sram_bus_port_test;
  import srsbp_pkg::*;
  localparam int REC = 20;
  logic       clock;
  logic       arst_n;
  logic       scl;
  logic       sda_m;
  logic       sda_wire;
  logic       sda_out;
  logic       sda_oe_n;
  logic       osc_32k;
  logic       power_fail_in;
  logic       battery_switch_in;
  logic       reset_oe_n;
  logic       res_stb;
  logic [8:0] res;
  logic [8:0] e;
  logic [8:0] expected_q[$];
  logic [7:0] d0;
  logic [7:0] tset[9] = '{8'h99, 8'h80, 8'h59, 8'h59, 8'h23, 8'h03,
                          8'h28, 8'h02, 8'h23};
  logic [7:0] texp[9] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h04,
                          8'h01, 8'h03, 8'h23};
  int         miscompares;
  int         n_tests;
  // pull-up wins unless someone pulls low
  assign sda_wire = sda_oe_n ? sda_m : (sda_m & sda_out);
  srsbp_top #(.RECOVERY_CYCLES(REC)) u_srsbp_top (
    .clock(clock), .arst_n(arst_n), .scl(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .osc_32k(osc_32k),
    .power_fail_in(power_fail_in), .battery_switch_in(battery_switch_in),
    .reset_out(), .reset_oe_n(reset_oe_n));
  srsbp_master u_srsbp_master (
    .scl(scl), .sda_m(sda_m), .sda_wire(sda_wire),
    .res_stb(res_stb), .res(res));
  always #2 clock = ~clock;
  task automatic check_byte(input string what, input logic [7:0] ex,
                            input logic [7:0] s);
    n_tests++;
    if (s !== ex)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, ex, s);
    end
  endtask
  task automatic check_bit(input string what, input logic ex,
                           input logic s);
    check_byte(what, {7'h00, ex}, {7'h00, s});
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] d, input logic ack);
    expected_q.push_back({8'h00, ack});
    u_srsbp_master.xfer(d, 1'b0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] ex, input logic ack);
    expected_q.push_back({1'b1, ex});
    u_srsbp_master.xfer(8'hFF, 1'b1, ack);
  endtask
  task automatic set_ptr(input logic [15:0] a);
    u_srsbp_master.start(1'b0);
    wr(SLAVE_ADDR_BYTE, 1'b1);
    wr(a[15:8], 1'b1);
    wr(a[7:0], 1'b1);
  endtask
  task automatic rd_from(input logic [15:0] a);
    set_ptr(a);
    u_srsbp_master.start(1'b1);
    wr(SLAVE_ADDR_BYTE | 8'h01, 1'b1);
  endtask
  // settled sampling on the falling edge, bounded
  task automatic wait_rst(input logic lvl, input int lim);
    for (int i = 0; i < lim && reset_oe_n !== lvl; i++)
      @(negedge clock);
    check_bit("reset_oe_n", lvl, reset_oe_n);
    if (reset_oe_n !== lvl)
      results();
  endtask
  always @(posedge res_stb)
  begin
    if (expected_q.size() == 0)
      check_bit("unexpected byte", 1'b0, 1'b1);
    else
    begin
      e = expected_q.pop_front();
      if (e[8])
        check_byte("read data", e[7:0], res[7:0]);
      else
        check_bit("ack", e[0], res[0]);
    end
  end
  initial
  begin
    clock = 1'b0;
    arst_n = 1'b0;
    osc_32k = 1'b0;
    power_fail_in = 1'b0;
    battery_switch_in = 1'b0;
    miscompares = 0;
    n_tests = 0;
    void'($urandom(95));
    repeat (12) @(posedge clock);
    #1 arst_n = 1'b1;
    repeat (4) step();
    d0 = 8'($urandom());
    if (d0[7:1] == SLAVE_ADDR_BYTE[7:1])
      d0 = d0 ^ 8'h02;
    u_srsbp_master.start(1'b0);
    wr(d0, 1'b0);
    u_srsbp_master.stop();
    $display("test foreign address done");
    d0 = 8'($urandom());
    set_ptr(16'hFFEE);
    wr(d0, 1'b1);
    wr(~d0, 1'b1);
    wr(8'h5C, 1'b1);
    u_srsbp_master.stop();
    rd_from(16'h7FEE);
    rd(d0, 1'b1);
    rd(~d0, 1'b1);
    rd(8'h00, 1'b0);
    u_srsbp_master.stop();
    $display("test ram and reserved done");
    set_ptr({1'b0, A_SUBSEC});
    foreach (tset[i])
      wr(tset[i], 1'b1);
    u_srsbp_master.stop();
    set_ptr({1'b0, A_CAL});
    wr(8'h00, 1'b1);
    u_srsbp_master.stop();
    // 328 rises give exactly one hundredth tick
    repeat (656)
    begin
      repeat (4) step();
      osc_32k = ~osc_32k;
    end
    set_ptr({1'b0, A_CAL});
    wr(8'h80, 1'b1);
    u_srsbp_master.stop();
    rd_from({1'b0, A_SUBSEC});
    foreach (texp[i])
      rd(texp[i], i != 8);
    u_srsbp_master.stop();
    $display("test calendar roll done");
    set_ptr({1'b0, A_YEAR});
    wr(8'h45, 1'b1);
    wr(8'h5A, 1'b1);
    wr(8'hC3, 1'b1);
    u_srsbp_master.stop();
    rd_from({1'b0, A_YEAR});
    rd(8'h45, 1'b1);
    rd(8'h5A, 1'b0);
    u_srsbp_master.stop();
    u_srsbp_master.start(1'b0);
    wr(SLAVE_ADDR_BYTE | 8'h01, 1'b1);
    rd(8'hC3, 1'b0);
    u_srsbp_master.stop();
    $display("test pointer wrap done");
    set_ptr(16'h0005);
    step();
    power_fail_in = 1'b1;
    wait_rst(1'b0, 8);
    step();
    battery_switch_in = 1'b1;
    wait_rst(1'b1, 8);
    step();
    battery_switch_in = 1'b0;
    wait_rst(1'b0, 8);
    wr(8'h77, 1'b0);
    u_srsbp_master.stop();
    u_srsbp_master.start(1'b0);
    wr(SLAVE_ADDR_BYTE, 1'b0);
    u_srsbp_master.stop();
    step();
    power_fail_in = 1'b0;
    repeat (REC - 4) @(negedge clock);
    check_bit("reset_oe_n", 1'b0, reset_oe_n);
    wait_rst(1'b1, 16);
    u_srsbp_master.start(1'b0);
    wr(SLAVE_ADDR_BYTE | 8'h01, 1'b1);
    rd(8'h5A, 1'b0);
    u_srsbp_master.stop();
    $display("test power fail done");
    results();
  end
endmodule
